/* File: inc/erase_host_pkg.sv */
// Purpose: Shared constants and types for the bulk erase host sequencer.
// Assumes: Core clock of 10 MHz (100 ns period).
// Notes: Command codes and timing figures are those of the flash part driven.
package erase_host_pkg;
    localparam int CLK_PERIOD_NS = 100;
    // Command codes written to the flash command latch.
    localparam logic [7:0] CMD_READ = 8'h00;
    localparam logic [7:0] CMD_ERASE = 8'h20;
    localparam logic [7:0] CMD_PROG_SETUP = 8'h40;
    localparam logic [7:0] CMD_VERIFY = 8'hA0;
    localparam logic [7:0] CMD_RESET = 8'hFF;
    localparam logic [7:0] DATA_ERASED = 8'hFF;
    localparam logic [7:0] DATA_ZERO = 8'h00;
    localparam logic [15:0] ADDR_FIRST = 16'h0000;
    // Timing figures in their own units and derived cycle counts.
    localparam int ERASE_TIME_MS = 10;
    localparam int ERASE_CYCLES = (ERASE_TIME_MS * 1000000) / CLK_PERIOD_NS;
    localparam int SETTLE_TIME_US = 6;
    localparam int SETTLE_CYCLES = (SETTLE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PROG_TIME_US = 10;
    localparam int PROG_CYCLES = (PROG_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int MAX_PULSES = 1000;
    // Bus strobe phase lengths in cycles.
    localparam logic [3:0] PHASE_CYCLES = 4'h3;
    localparam logic [7:0] BUS_IDLE_DATA = 8'h00;

    // One bus cycle toward the flash pins.
    typedef struct packed {
        logic ce_n;
        logic oe_n;
        logic we_n;
        logic [15:0] addr;
        logic [7:0] dout;
        logic dq_oe_n;
    } flash_bus_t;
endpackage

/* File: src/erase_host.sv */
// Purpose: Host sequencer that bulk erases a byte-wide flash through its pins.
// Assumes: One 10 MHz clock; flash read data arrives asynchronously on DQ_IN.
// Notes: Fill-to-zero uses byte program with program-verify before erase.
`timescale 1ns/100ps
`default_nettype none
module erase_host
    import erase_host_pkg::*;
#(
    parameter int ADDR_W = 16,
    parameter logic [15:0] LAST_ADDR = 16'hFFFF,
    parameter int ERASE_WAIT = ERASE_CYCLES,
    parameter int MAX_PULSE_COUNT = MAX_PULSES
) (
    input wire logic CORE_CLK,
    input wire logic RESET_N,
    input wire logic START,
    input wire logic [7:0] DQ_IN,
    output logic [15:0] ADDR,
    output logic [7:0] DQ_OUT,
    output logic DQ_OE_N,
    output logic CE_N,
    output logic OE_N,
    output logic WE_N,
    output logic BUSY,
    output logic DONE,
    output logic FAIL,
    output logic [9:0] PULSE_TALLY
);
    typedef enum {
        ST_IDLE, ST_SCAN_RD, ST_FILL_SETUP, ST_FILL_PROG, ST_FILL_WAIT,
        ST_FILL_VFY, ST_FILL_SETTLE, ST_FILL_RD, ST_ERS_SETUP, ST_ERS_GO,
        ST_ERS_WAIT, ST_VFY_CMD, ST_VFY_SETTLE, ST_VFY_RD, ST_EXIT_CMD,
        ST_END_CMD, ST_FINISH
    } state_t;
    typedef enum {BUS_IDLE, BUS_SETUP, BUS_STROBE, BUS_HOLD} bus_t;

    state_t state_q;
    bus_t bus_q;
    flash_bus_t pins_q;
    logic [15:0] addr_q;
    logic [7:0] wdata_q;
    logic rd_q;
    logic go_q;
    logic bus_done_q;
    logic [7:0] rdata_q;
    logic [3:0] phase_q;
    logic [31:0] wait_q;
    logic [9:0] erase_pulse_tally;
    logic erased_all_q;
    logic fail_q;
    logic [7:0] dq_s1_q;
    logic [7:0] dq_s2_q;
    logic [7:0] dq_s3_q;

    ////////////////////////////////////////////////////////////////////////
    // Three-stage capture of read data; the value is used once the last two stages agree.
    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            dq_s1_q <= 8'h00;
            dq_s2_q <= 8'h00;
            dq_s3_q <= 8'h00;
        end else begin
            dq_s1_q <= DQ_IN;
            dq_s2_q <= dq_s1_q;
            dq_s3_q <= dq_s2_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Bus cycle engine: setup, strobe low, hold, each PHASE_CYCLES long.
    // Address and data are set in setup so they stand before the one strobe
    // of the cycle (OE_N or WE_N) falls and stay through its rise and the hold.
    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            bus_q <= BUS_IDLE;
            phase_q <= 4'h0;
            bus_done_q <= 1'b0;
            rdata_q <= 8'h00;
            pins_q <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: 16'h0000,
                        dout: BUS_IDLE_DATA, dq_oe_n: 1'b1};
        end else begin
            bus_done_q <= 1'b0;
            case (bus_q)
                BUS_IDLE: begin
                    if (go_q) begin
                        pins_q.addr <= addr_q;
                        pins_q.dout <= wdata_q;
                        pins_q.dq_oe_n <= rd_q;
                        pins_q.ce_n <= 1'b0;
                        phase_q <= PHASE_CYCLES;
                        bus_q <= BUS_SETUP;
                    end
                end
                BUS_SETUP: begin
                    phase_q <= phase_q - 4'h1;
                    if (phase_q == 4'h1) begin
                        pins_q.we_n <= rd_q;
                        pins_q.oe_n <= !rd_q;
                        phase_q <= PHASE_CYCLES;
                        bus_q <= BUS_STROBE;
                    end
                end
                BUS_STROBE: begin
                    phase_q <= phase_q - 4'h1;
                    if (phase_q == 4'h1) begin
                        pins_q.we_n <= 1'b1;
                        pins_q.oe_n <= 1'b1;
                        phase_q <= PHASE_CYCLES;
                        bus_q <= BUS_HOLD;
                    end
                end
                BUS_HOLD: begin
                    phase_q <= phase_q - 4'h1;
                    // The last stage lags the pins by three edges, so read data
                    // is only trusted here, while the last two stages agree.
                    if (dq_s2_q == dq_s3_q) begin
                        rdata_q <= dq_s3_q;
                    end
                    if (phase_q == 4'h1) begin
                        pins_q.ce_n <= 1'b1;
                        pins_q.dq_oe_n <= 1'b1;
                        bus_done_q <= 1'b1;
                        bus_q <= BUS_IDLE;
                    end
                end
                default: bus_q <= BUS_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Erase flow sequencer; issues one bus cycle at a time and waits.
    // Read data comes from the hold phase of the bus engine, so a compare
    // made on bus_done_q always sees the byte of the cycle just ended.
    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            state_q <= ST_IDLE;
            go_q <= 1'b0;
            rd_q <= 1'b1;
            addr_q <= ADDR_FIRST;
            wdata_q <= CMD_READ;
            wait_q <= 32'h0000_0000;
            erase_pulse_tally <= 10'h000;
            erased_all_q <= 1'b1;
            fail_q <= 1'b0;
        end else begin
            go_q <= 1'b0;
            if (wait_q != 32'h0000_0000) begin
                wait_q <= wait_q - 32'h0000_0001;
            end
            case (state_q)
                ST_IDLE: begin
                    if (START) begin
                        fail_q <= 1'b0;
                        erased_all_q <= 1'b1;
                        addr_q <= ADDR_FIRST;
                        erase_pulse_tally <= 10'h000;
                        rd_q <= 1'b1;
                        go_q <= 1'b1;
                        state_q <= ST_SCAN_RD;
                    end
                end
                ST_SCAN_RD: begin
                    if (bus_done_q) begin
                        if (rdata_q != DATA_ERASED) begin
                            erased_all_q <= 1'b0;
                        end
                        if (addr_q == LAST_ADDR) begin
                            addr_q <= ADDR_FIRST;
                            rd_q <= 1'b0;
                            wdata_q <= (erased_all_q && rdata_q == DATA_ERASED) ?
                                CMD_RESET : CMD_PROG_SETUP;
                            go_q <= 1'b1;
                            state_q <= (erased_all_q && rdata_q == DATA_ERASED) ?
                                ST_FINISH : ST_FILL_SETUP;
                        end else begin
                            addr_q <= addr_q + 16'h0001;
                            go_q <= 1'b1;
                        end
                    end
                end
                ST_FILL_SETUP: begin
                    if (bus_done_q) begin
                        wdata_q <= DATA_ZERO;
                        go_q <= 1'b1;
                        state_q <= ST_FILL_PROG;
                    end
                end
                ST_FILL_PROG: begin
                    if (bus_done_q) begin
                        wait_q <= 32'(PROG_CYCLES);
                        state_q <= ST_FILL_WAIT;
                    end
                end
                ST_FILL_WAIT: begin
                    if (wait_q == 32'h0000_0000) begin
                        wdata_q <= 8'hC0;
                        go_q <= 1'b1;
                        state_q <= ST_FILL_VFY;
                    end
                end
                ST_FILL_VFY: begin
                    if (bus_done_q) begin
                        wait_q <= 32'(SETTLE_CYCLES);
                        state_q <= ST_FILL_SETTLE;
                    end
                end
                ST_FILL_SETTLE: begin
                    if (wait_q == 32'h0000_0000) begin
                        rd_q <= 1'b1;
                        go_q <= 1'b1;
                        state_q <= ST_FILL_RD;
                    end
                end
                ST_FILL_RD: begin
                    if (bus_done_q) begin
                        rd_q <= 1'b0;
                        go_q <= 1'b1;
                        if (rdata_q != DATA_ZERO) begin
                            wdata_q <= CMD_PROG_SETUP;
                            state_q <= ST_FILL_SETUP;
                        end else if (addr_q == LAST_ADDR) begin
                            addr_q <= ADDR_FIRST;
                            wdata_q <= CMD_ERASE;
                            state_q <= ST_ERS_SETUP;
                        end else begin
                            addr_q <= addr_q + 16'h0001;
                            wdata_q <= CMD_PROG_SETUP;
                            state_q <= ST_FILL_SETUP;
                        end
                    end
                end
                ST_ERS_SETUP: begin
                    if (bus_done_q) begin
                        go_q <= 1'b1;
                        state_q <= ST_ERS_GO;
                    end
                end
                ST_ERS_GO: begin
                    if (bus_done_q) begin
                        wait_q <= 32'(ERASE_WAIT);
                        erase_pulse_tally <= erase_pulse_tally + 10'h001;
                        state_q <= ST_ERS_WAIT;
                    end
                end
                ST_ERS_WAIT: begin
                    if (wait_q == 32'h0000_0000) begin
                        wdata_q <= CMD_VERIFY;
                        go_q <= 1'b1;
                        state_q <= ST_VFY_CMD;
                    end
                end
                ST_VFY_CMD: begin
                    if (bus_done_q) begin
                        wait_q <= 32'(SETTLE_CYCLES);
                        state_q <= ST_VFY_SETTLE;
                    end
                end
                ST_VFY_SETTLE: begin
                    if (wait_q == 32'h0000_0000) begin
                        rd_q <= 1'b1;
                        go_q <= 1'b1;
                        state_q <= ST_VFY_RD;
                    end
                end
                ST_VFY_RD: begin
                    if (bus_done_q) begin
                        rd_q <= 1'b0;
                        if (rdata_q != DATA_ERASED) begin
                            if (32'(erase_pulse_tally) >= 32'(MAX_PULSE_COUNT)) begin
                                fail_q <= 1'b1;
                                wdata_q <= CMD_RESET;
                                go_q <= 1'b1;
                                state_q <= ST_END_CMD;
                            end else begin
                                wdata_q <= CMD_ERASE;
                                go_q <= 1'b1;
                                state_q <= ST_ERS_SETUP;
                            end
                        end else if (addr_q == LAST_ADDR) begin
                            wdata_q <= CMD_READ;
                            go_q <= 1'b1;
                            state_q <= ST_EXIT_CMD;
                        end else begin
                            addr_q <= addr_q + 16'h0001;
                            wdata_q <= CMD_VERIFY;
                            go_q <= 1'b1;
                            state_q <= ST_VFY_CMD;
                        end
                    end
                end
                ST_EXIT_CMD: begin
                    if (bus_done_q) begin
                        wdata_q <= CMD_RESET;
                        go_q <= 1'b1;
                        state_q <= ST_END_CMD;
                    end
                end
                ST_END_CMD: begin
                    if (bus_done_q) begin
                        go_q <= 1'b1;
                        state_q <= ST_FINISH;
                    end
                end
                ST_FINISH: begin
                    if (bus_done_q) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Status outputs, registered.
    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            BUSY <= 1'b0;
            DONE <= 1'b0;
            FAIL <= 1'b0;
            PULSE_TALLY <= 10'h000;
        end else begin
            BUSY <= (state_q != ST_IDLE);
            DONE <= (state_q == ST_FINISH) && bus_done_q;
            FAIL <= fail_q;
            PULSE_TALLY <= erase_pulse_tally;
        end
    end

    // Pin outputs come straight from the bus engine flops.
    assign ADDR = pins_q.addr;
    assign DQ_OUT = pins_q.dout;
    assign DQ_OE_N = pins_q.dq_oe_n;
    assign CE_N = pins_q.ce_n;
    assign OE_N = pins_q.oe_n;
    assign WE_N = pins_q.we_n;
endmodule
`default_nettype wire

/* File: test/erase_host_sva.sv */
// Purpose: Pin timing and flow checks on the erase host.
// Assumes: One clock domain, async active-low reset.
// Notes: gap_q counts cycles since the latest write strobe rise.
`timescale 1ns/100ps
`default_nettype none
module erase_host_sva
    import erase_host_pkg::*;
#(
    parameter int ERASE_WAIT = 20,
    parameter int MAX_PULSE_COUNT = 3
) (
    input wire logic CORE_CLK,
    input wire logic RESET_N,
    input wire logic START,
    input wire logic [7:0] DQ_IN,
    input wire logic [15:0] ADDR,
    input wire logic [7:0] DQ_OUT,
    input wire logic DQ_OE_N,
    input wire logic CE_N,
    input wire logic OE_N,
    input wire logic WE_N,
    input wire logic BUSY,
    input wire logic DONE,
    input wire logic FAIL,
    input wire logic [9:0] PULSE_TALLY
);
    logic [1:0] arm_q;
    logic [7:0] cmd_q;
    int gap_q;
    ////////////////////////////////////////////////////////////////////////////
    // Saturate the gap so a long idle never wraps into a short one.
    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            arm_q <= 2'h0;
            cmd_q <= 8'h00;
            gap_q <= 0;
        end else if ($rose(WE_N)) begin
            arm_q <= (DQ_OUT != CMD_ERASE) ? 2'h0 : (arm_q == 2'h1) ? 2'h2 : 2'h1;
            cmd_q <= DQ_OUT;
            gap_q <= 0;
        end else if (gap_q < 100000) begin
            gap_q <= gap_q + 1;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (!RESET_N);
    strobe_excl_a: assert property (!(!OE_N && !WE_N))
        else $error("Read and write strobes low together");
    write_qual_a: assert property (!WE_N |-> !CE_N && OE_N && !DQ_OE_N)
        else $error("Write strobe without select or data drive");
    we_width_a: assert property ($fell(WE_N) |-> !WE_N [*3] ##1 WE_N)
        else $error("Write strobe width wrong");
    ce_width_a: assert property ($fell(CE_N) |-> !CE_N [*8] ##1 !CE_N ##1 CE_N)
        else $error("Select width wrong");
    addr_hold_a: assert property (!CE_N && !$past(CE_N) |-> $stable(ADDR))
        else $error("Address moved while selected");
    data_hold_a: assert property ($rose(WE_N) |-> $stable(DQ_OUT) && !DQ_OE_N)
        else $error("Data moved at write strobe rise");
    erase_wait_a: assert property ($fell(WE_N) && arm_q == 2'h2 |-> gap_q >= ERASE_WAIT)
        else $error("Write too soon after erase start");
    settle_a: assert property ($fell(OE_N) && cmd_q == CMD_VERIFY |-> gap_q >= SETTLE_CYCLES)
        else $error("Verify read before settling");
    tally_cap_a: assert property (PULSE_TALLY <= MAX_PULSE_COUNT)
        else $error("Pulse tally over limit");
    fail_tally_a: assert property ($rose(FAIL) |-> PULSE_TALLY == MAX_PULSE_COUNT)
        else $error("Failure flagged with pulses left");
    done_reset_a: assert property ($rose(DONE) |-> cmd_q == CMD_RESET ##1 !DONE)
        else $error("Flow ended without read mode command");
    pass_cov: cover property (DONE && !FAIL);
    fail_cov: cover property (DONE && FAIL);
    erase_cov: cover property ($fell(WE_N) && arm_q == 2'h2);
endmodule
bind erase_host erase_host_sva #(
    .ERASE_WAIT(ERASE_WAIT),
    .MAX_PULSE_COUNT(MAX_PULSE_COUNT)
) i_sva (
    .CORE_CLK(CORE_CLK), .RESET_N(RESET_N), .START(START), .DQ_IN(DQ_IN),
    .ADDR(ADDR), .DQ_OUT(DQ_OUT), .DQ_OE_N(DQ_OE_N), .CE_N(CE_N), .OE_N(OE_N),
    .WE_N(WE_N), .BUSY(BUSY), .DONE(DONE), .FAIL(FAIL), .PULSE_TALLY(PULSE_TALLY)
);
`default_nettype wire

/* File: test/flash_model.sv */
// Purpose: Behavioural byte-wide flash on the far side of the erase host.
// Assumes: The bench presets mem and need before each run.
// Notes: errs counts host flow slips; need sets pulses each byte takes.
`timescale 1ns/100ps
`default_nettype none
module flash_model
    import erase_host_pkg::*;
#(
    parameter int DEPTH = 4,
    parameter int ERASE_WAIT = 20,
    parameter int MAX_PULSE_COUNT = 3
) (
    input wire logic core_clk,
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic [15:0] addr,
    input wire logic [7:0] dout,
    output logic [7:0] rdata
);
    logic [7:0] mem [DEPTH];
    int need [DEPTH];
    logic [7:0] cmd = CMD_READ;
    logic [7:0] last = 8'h00;
    logic [15:0] lat_a, pa, va;
    logic armed = 1'b0;
    logic prog = 1'b0;
    logic fresh = 1'b0;
    int cyc = 0, t_we = 0, t_cmd = 0, pulses = 0, v_next = 0, errs = 0;
    wire logic [7:0] rd;
    ////////////////////////////////////////////////////////////////////////////
    // margin read of latched byte
    assign rd = cmd == CMD_VERIFY ? mem[va] : cmd == 8'hC0 ? mem[pa] : mem[addr];
    // Released lines flip so a stale byte never passes as fresh data.
    assign rdata = (!ce_n && !oe_n) ? rd : ~last;
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (!ce_n && !oe_n) last <= rd;
    end
    always @(negedge we_n or negedge ce_n) if (!we_n && !ce_n && oe_n) lat_a = addr;
    always @(posedge we_n) if (!ce_n && oe_n) take(dout);
    task automatic take(input logic [7:0] d);
        if (prog) begin
            mem[lat_a] = mem[lat_a] & d;
            pa = lat_a;
            prog = 1'b0;
            fresh = 1'b1;
        end else if (d == CMD_ERASE && armed) begin
            // parallel erase from a zero fill
            if (fresh) pulses = 0;
            if (fresh) v_next = 0;
            for (int i = 0; i < DEPTH; i++) begin
                if (fresh && mem[i] != DATA_ZERO) errs++;
                if (pulses + 1 >= need[i]) mem[i] = DATA_ERASED;
            end
            pulses++;
            fresh = 1'b0;
            armed = 1'b0;
            t_we = cyc;
            if (pulses > MAX_PULSE_COUNT) errs++;
        end else begin
            armed = (d == CMD_ERASE);
            if (d == CMD_VERIFY && (pulses == 0 || cyc - t_we < ERASE_WAIT)) errs++;
            if (d == CMD_VERIFY && lat_a != v_next) errs++;
            if (!(d inside {CMD_READ, CMD_ERASE, CMD_PROG_SETUP, CMD_VERIFY, CMD_RESET, 8'hC0}))
                errs++;
            if (d == CMD_VERIFY) va = lat_a;
            prog = (d == CMD_PROG_SETUP);
            t_cmd = cyc;
            cmd = (d == CMD_RESET) ? CMD_READ : d;
        end
    endtask
    always @(negedge oe_n) if (!ce_n && cmd == CMD_VERIFY && cyc - t_cmd < SETTLE_CYCLES) errs++;
    // a passing byte moves the scan on
    always @(posedge oe_n) if (!ce_n && cmd == CMD_VERIFY && mem[va] == DATA_ERASED) v_next = va + 1;
endmodule
`default_nettype wire

/* File: test/bulk_erase_verify_sequence_bench.sv */
// Purpose: Self-checking bench of the erase host against a flash model.
// Assumes: Four-byte array, short erase wait, budget of three pulses.
// Notes: Notes queued by the driver are retired on each done pulse.
`timescale 1ns/100ps
`default_nettype none
module bulk_erase_verify_sequence_bench
    import erase_host_pkg::*;
;
    localparam int EW = 20;
    localparam int MAXP = 3;
    typedef struct packed {logic fail; logic [9:0] tally; logic allff;} note_t;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic start = 1'b0;
    logic [7:0] dq_in, dq_out;
    logic [15:0] addr;
    logic [9:0] tally;
    logic dq_oe_n, ce_n, oe_n, we_n, busy, done, fail;
    note_t notes [$];
    note_t note;
    int bad_count = 0;
    int checked = 0;
    int seen = 0;
    logic [31:0] rng = 32'h0000_3AA6;
    ////////////////////////////////////////////////////////////////////////////
    always #50 core_clk = ~core_clk;
    erase_host #(.LAST_ADDR(16'h0003), .ERASE_WAIT(EW), .MAX_PULSE_COUNT(MAXP)) i_dut (
        .CORE_CLK(core_clk), .RESET_N(reset_n), .START(start), .DQ_IN(dq_in),
        .ADDR(addr), .DQ_OUT(dq_out), .DQ_OE_N(dq_oe_n), .CE_N(ce_n), .OE_N(oe_n),
        .WE_N(we_n), .BUSY(busy), .DONE(done), .FAIL(fail), .PULSE_TALLY(tally)
    );
    flash_model #(.DEPTH(4), .ERASE_WAIT(EW), .MAX_PULSE_COUNT(MAXP)) i_flash (
        .core_clk(core_clk), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .addr(addr),
        .dout(dq_out), .rdata(dq_in)
    );
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rand_next();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction
    function automatic logic all_erased();
        all_erased = 1'b1;
        for (int i = 0; i < 4; i++) if (i_flash.mem[i] !== DATA_ERASED) all_erased = 1'b0;
    endfunction
    task automatic compare(input string what, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic finish_test();
        $display("Counts: checked %0d, bad %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // Loads the array, notes the outcome, starts the flow and waits for done.
    // A second start while busy must be refused, so one done is expected.
    task automatic run(input string name, input int top, input logic ff, input int hard);
        note_t n;
        int worst;
        int w;
        worst = 0;
        for (int i = 0; i < 4; i++) begin
            i_flash.mem[i] = ff ? DATA_ERASED : (rand_next() & 32'h0000_007F);
            i_flash.need[i] = (i == 2 && hard > 0) ? hard : 1 + int'(rand_next() % top);
            if (i_flash.need[i] > worst) worst = i_flash.need[i];
        end
        n.fail = !ff && worst > MAXP;
        n.tally = ff ? 10'h000 : n.fail ? 10'(MAXP) : 10'(worst);
        n.allff = !n.fail;
        notes.push_back(n);
        w = seen;
        start = 1'b1;
        @(negedge core_clk);
        start = 1'b0;
        repeat (100) @(negedge core_clk);
        start = (busy === 1'b1);
        @(negedge core_clk);
        start = 1'b0;
        for (int k = 0; k < 30000 && seen == w; k++) @(negedge core_clk);
        if (seen == w) begin
            bad_count++;
            finish_test();
        end
        repeat (60) @(negedge core_clk);
        $display("Test %s ended", name);
    endtask
    // Each done pulse retires the oldest note.
    always @(negedge core_clk) begin
        if (done === 1'b1) begin
            if (notes.size() == 0) begin
                compare("spare done", 16'h0000, 16'h0001);
            end else begin
                note = notes.pop_front();
                seen++;
                compare("fail", 16'(note.fail), 16'(fail));
                compare("busy", 16'h0001, 16'(busy));
                compare("tally", 16'(note.tally), 16'(tally));
                compare("model slips", 16'h0000, 16'(i_flash.errs));
                compare("latch mode", 16'(CMD_READ), 16'(i_flash.cmd));
                compare("erased", 16'(note.allff), 16'(all_erased()));
            end
        end
    end
    initial begin
        repeat (20) @(posedge core_clk);
        @(negedge core_clk);
        reset_n = 1'b1;
        run("already erased", 1, 1'b1, 0);
        run("erase with retries", 3, 1'b0, 0);
        run("pulses exhausted", 2, 1'b0, MAXP + 2);
        finish_test();
    end
endmodule
`default_nettype wire
